// [inc/btsh_regs.svh]
// Purpose: Constants for the block transfer service handler.
// Assumes: Words are 16 bits; one word moves per clock on the link.
// Notes:   Included by both ends, the assertions and the bench.
`ifndef BTSH_REGS_SVH
`define BTSH_REGS_SVH
`define BTSH_CODE_ERR_TABLE   16'h26DE
`define BTSH_CODE_TIME_READ   16'h26F2
`define BTSH_CODE_TIME_SET    16'h26F3
`define BTSH_CODE_WARM        16'h270E
`define BTSH_CODE_COLD        16'h270F
`define BTSH_CMD_MAX          11'h3E8
`define BTSH_CNT_MAX          8'hC8
`define BTSH_LEN_60           8'h3C
`define BTSH_LEN_120          8'h78
`define BTSH_LEN_240          8'hF0
`define BTSH_ERR_FIRST_WORD   8'h04
`define BTSH_TIME_RD_FIRST    8'h02
`define BTSH_TIME_RD_LAST     8'h08
`define BTSH_TIME_SET_FIRST   8'h01
`define BTSH_TIME_SET_LAST    8'h07
`define BTSH_NEXT_BLOCK_RST   16'h0000
`endif

// [inc/btsh_pkg.sv]
// Purpose: Types shared by both ends of the service handler.
// Assumes: Nothing beyond the constant header.
// Notes:   Block size select codes map to 60, 120 and 240 words.
package btsh_pkg;
  typedef enum logic [1:0] {
    BTSH_SIZE_60  = 2'h0,
    BTSH_SIZE_120 = 2'h1,
    BTSH_SIZE_240 = 2'h2
  } btsh_size_t;

  typedef enum logic [2:0] {
    BTSH_DEV_IDLE = 3'h0,
    BTSH_DEV_RECV = 3'h6,
    BTSH_DEV_DECIDE = 3'h1,
    BTSH_DEV_SEND = 3'h2,
    BTSH_DEV_FETCH = 3'h3
  } btsh_dev_state_t;

  typedef enum logic [1:0] {
    BTSH_HOST_IDLE = 2'h0,
    BTSH_HOST_SEND = 2'h1,
    BTSH_HOST_RECV = 2'h3
  } btsh_host_state_t;
endpackage

// [inc/btsh_link_if.sv]
// Purpose: Block transfer link between host and device.
// Assumes: One clock; one word per cycle while the strobe is high.
// Notes:   Each block is framed by a last-word marker.
`timescale 1ns/100ps
interface btsh_link_if;
  logic        req_valid;
  logic [15:0] req_word;
  logic        req_last;
  logic        rsp_valid;
  logic [15:0] rsp_word;
  logic        rsp_last;

  modport host (
    output req_valid, req_word, req_last,
    input  rsp_valid, rsp_word, rsp_last
  );
  modport device (
    input  req_valid, req_word, req_last,
    output rsp_valid, rsp_word, rsp_last
  );
endinterface

// [rtl/btsh_host.sv]
// Purpose: Host end; sends one service block and collects any reply.
// Assumes: Caller holds the block words stable on the word port while busy.
// Notes:   Request word n is taken from blk_word while blk_index shows n.
`timescale 1ns/100ps
`include "btsh_regs.svh"
module btsh_host
  import btsh_pkg::*;
(
  input  wire logic        ref_clk,     // Clock.
  input  wire logic        rst_n,       // Synchronous reset, active low.
  btsh_link_if.host        link,        // Link to the device.
  input  wire btsh_size_t  blk_size,    // Configured block size.
  input  wire logic        start,       // Pulse to send a block.
  input  wire logic [15:0] blk_word,    // Word at blk_index.
  input  wire logic        expect_rsp,  // Wait for a reply after sending.
  output logic      [7:0]  blk_index,   // Index of word wanted.
  output logic             busy,        // Transfer in progress.
  output logic             rsp_valid,   // Reply word strobe.
  output logic      [15:0] rsp_word,    // Reply word.
  output logic      [7:0]  rsp_index    // Reply word index.
);
  btsh_host_state_t state_reg;
  logic [7:0]       len;
  logic [7:0]       cnt_reg;
  logic             exp_reg;
  logic             valid_reg;
  logic [15:0]      word_reg;
  logic             last_reg;

  always_comb begin
    case (blk_size)
      BTSH_SIZE_120: len = `BTSH_LEN_120;   // [RULE4]
      BTSH_SIZE_240: len = `BTSH_LEN_240;
      default:       len = `BTSH_LEN_60;
    endcase
  end

  assign link.req_valid = valid_reg;
  assign link.req_word  = word_reg;
  assign link.req_last  = last_reg;
  assign blk_index      = cnt_reg;
  assign busy           = (state_reg != BTSH_HOST_IDLE);

  // ---------------------------------------------------------------------
  // Request sequencing
  // ---------------------------------------------------------------------
  // The caller places the codes and fields of RULE1, RULE2, RULE3, RULE10,
  // RULE13, RULE15 and RULE16 in the block words; this end only frames them.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= BTSH_HOST_IDLE;
      cnt_reg   <= 8'h00;
      exp_reg   <= 1'b0;
      valid_reg <= 1'b0;
      word_reg  <= 16'h0000;
      last_reg  <= 1'b0;
    end else begin
      case (state_reg)
        BTSH_HOST_IDLE: begin
          valid_reg <= 1'b0;
          last_reg  <= 1'b0;
          if (start) begin
            state_reg <= BTSH_HOST_SEND;
            exp_reg   <= expect_rsp;
            cnt_reg   <= 8'h00;
          end
        end
        BTSH_HOST_SEND: begin
          valid_reg <= 1'b1;
          word_reg  <= blk_word;                  // [RULE1] [RULE13]
          last_reg  <= (cnt_reg == len - 8'h01);  // [RULE4]
          cnt_reg   <= cnt_reg + 8'h01;
          if (cnt_reg == len - 8'h01) begin
            state_reg <= exp_reg ? BTSH_HOST_RECV : BTSH_HOST_IDLE;
          end
        end
        BTSH_HOST_RECV: begin
          valid_reg <= 1'b0;
          last_reg  <= 1'b0;
          if (start) begin
            state_reg <= BTSH_HOST_IDLE;
          end else if (link.rsp_valid && link.rsp_last) begin
            state_reg <= BTSH_HOST_IDLE;
          end
        end
        default: state_reg <= BTSH_HOST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Reply capture
  // ---------------------------------------------------------------------
  // Time words handed out here let the host set its own clock.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_word  <= 16'h0000;
      rsp_index <= 8'h00;
    end else begin
      rsp_valid <= link.rsp_valid;   // [RULE18]
      rsp_word  <= link.rsp_word;
      if (rsp_valid && !link.rsp_valid) begin
        rsp_index <= 8'h00;
      end else if (rsp_valid) begin
        rsp_index <= rsp_index + 8'h01;
      end
    end
  end
endmodule

// [rtl/btsh_device.sv]
// Purpose: Device end; decodes service blocks and builds replies.
// Assumes: One request word per cycle; replies are not back-pressured.
// Notes:   Error entries are written into the module over err_wr_*.
`timescale 1ns/100ps
`include "btsh_regs.svh"
// Contract
// (RULE1) Code 9950 in word zero requests errors.
// (RULE2) Host count word one is 1 to 200.
// (RULE3) Host start index within command list.
// (RULE4) Blocks are 60, 120 or 240 words.
// (RULE5) Error reply word zero holds zero.
// (RULE6) Reply word one holds next block code.
// (RULE7) Reply words two, three: count, start.
// (RULE8) Errors from word four, consecutive commands.
// (RULE9) Keep one error per command, 1000.
// (RULE10) Code 9970 asks for date and time.
// (RULE11) Time reply words two to eight.
// (RULE12) Time fields stay within calendar ranges; the module clock rolls the day over after 31 in every month.
// (RULE13) Code 9971 words one-seven load clock.
// (RULE14) No reply after a time-set block.
// (RULE15) Code 9998 requests warm restart.
// (RULE16) Code 9999 requests cold restart.
// (RULE17) Warm and cold restart behave identically.
// (RULE18) Host may set its clock from reply.
// (RULE19) No reply to out-of-range error requests.
module btsh_device
  import btsh_pkg::*;
(
  input  wire logic        ref_clk,        // Clock.
  input  wire logic        rst_n,          // Synchronous reset, active low.
  btsh_link_if.device      link,           // Link to the host.
  input  wire btsh_size_t  blk_size,       // Configured block size.
  input  wire logic [10:0] cmd_list_len,   // command_list_length, 1 to 1000.
  input  wire logic [15:0] next_block,     // Next block wanted from host.
  input  wire logic        err_wr_en,      // Record a command error.
  input  wire logic [9:0]  err_wr_idx,     // Command index for the record.
  input  wire logic [15:0] err_wr_val,     // Error value to record.
  input  wire logic        time_tick_ms,   // One-millisecond tick.
  output logic             reinit,         // Restart pulse, warm or cold.
  output logic             time_loaded,    // Clock was set pulse.
  output logic      [15:0] year_out        // Current year.
);
  btsh_dev_state_t state_reg;
  logic [7:0]      len;
  logic [7:0]      rx_idx_reg;
  logic [15:0]     code_reg;
  logic [15:0]     cnt_word_reg;
  logic [15:0]     start_word_reg;
  logic [15:0]     tset_reg [0:6];
  logic [15:0]     err_mem [0:999];
  logic [15:0]     tm_reg [0:6];
  logic [7:0]      tx_idx_reg;
  logic [15:0]     err_rd_reg;
  logic            rsp_valid_reg;
  logic [15:0]     rsp_word_reg;
  logic            rsp_last_reg;
  logic            reinit_reg;
  logic            tload_reg;
  logic            req_ok;
  logic [15:0]     end_idx;
  logic [15:0]     tx_word;
  logic [9:0]      rd_idx;
  logic [7:0]      ent;

  always_comb begin
    case (blk_size)
      BTSH_SIZE_120: len = `BTSH_LEN_120;   // [RULE4]
      BTSH_SIZE_240: len = `BTSH_LEN_240;
      default:       len = `BTSH_LEN_60;
    endcase
  end

  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_word  = rsp_word_reg;
  assign link.rsp_last  = rsp_last_reg;
  assign reinit         = reinit_reg;
  assign time_loaded    = tload_reg;
  assign year_out       = tm_reg[0];

  // ---------------------------------------------------------------------
  // Command error table
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 1000; gi = gi + 1) begin : g_err
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          err_mem[gi] <= 16'h0000;
        end else if (err_wr_en && (err_wr_idx == 10'(gi))) begin
          err_mem[gi] <= err_wr_val;   // [RULE9]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Request receive
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_idx_reg     <= 8'h00;
      code_reg       <= 16'h0000;
      cnt_word_reg   <= 16'h0000;
      start_word_reg <= 16'h0000;
      for (int i = 0; i < 7; i++) begin
        tset_reg[i] <= 16'h0000;
      end
    end else if (link.req_valid && state_reg != BTSH_DEV_SEND) begin
      rx_idx_reg <= link.req_last ? 8'h00 : rx_idx_reg + 8'h01;
      case (rx_idx_reg)
        8'h00:   code_reg       <= link.req_word;   // [RULE1] [RULE10]
        8'h01:   cnt_word_reg   <= link.req_word;
        8'h02:   start_word_reg <= link.req_word;
        default: ;
      endcase
      if (rx_idx_reg >= `BTSH_TIME_SET_FIRST && rx_idx_reg <= `BTSH_TIME_SET_LAST) begin
        tset_reg[rx_idx_reg[2:0] - 3'h1] <= link.req_word;   // [RULE13]
      end
    end
  end

  assign end_idx = cnt_word_reg + start_word_reg;
  assign req_ok  = (cnt_word_reg >= 16'h0001) && (cnt_word_reg <= 16'(`BTSH_CNT_MAX))
                && (start_word_reg < 16'(cmd_list_len))
                && (end_idx <= 16'(cmd_list_len));   // [RULE19]

  // ---------------------------------------------------------------------
  // Decode and reply sequencing
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg  <= BTSH_DEV_IDLE;
      tx_idx_reg <= 8'h00;
      reinit_reg <= 1'b0;
      tload_reg  <= 1'b0;
    end else begin
      reinit_reg <= 1'b0;
      tload_reg  <= 1'b0;
      case (state_reg)
        BTSH_DEV_IDLE: begin
          if (link.req_valid && link.req_last) begin
            state_reg <= BTSH_DEV_DECIDE;
          end
        end
        BTSH_DEV_DECIDE: begin
          state_reg  <= BTSH_DEV_IDLE;
          tx_idx_reg <= 8'h00;
          case (code_reg)
            `BTSH_CODE_ERR_TABLE: begin
              if (req_ok) state_reg <= BTSH_DEV_FETCH;   // [RULE19]
            end
            `BTSH_CODE_TIME_READ: state_reg <= BTSH_DEV_FETCH;   // [RULE10]
            `BTSH_CODE_TIME_SET:  tload_reg <= 1'b1;   // [RULE14]
            `BTSH_CODE_WARM,
            `BTSH_CODE_COLD:      reinit_reg <= 1'b1;   // [RULE15] [RULE16] [RULE17]
            default: ;
          endcase
        end
        BTSH_DEV_FETCH: state_reg <= BTSH_DEV_SEND;
        BTSH_DEV_SEND: begin
          tx_idx_reg <= tx_idx_reg + 8'h01;
          if (tx_idx_reg == len - 8'h01) state_reg <= BTSH_DEV_IDLE;   // [RULE4]
        end
        default: state_reg <= BTSH_DEV_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Reply word build
  // ---------------------------------------------------------------------
  // The error word is read one cycle ahead so the mux stays shallow.
  assign ent    = tx_idx_reg + 8'h01 - `BTSH_ERR_FIRST_WORD;
  assign rd_idx = 10'(start_word_reg + 16'(ent));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_rd_reg <= 16'h0000;
    end else begin
      err_rd_reg <= err_mem[rd_idx];   // [RULE8]
    end
  end

  always_comb begin
    tx_word = 16'h0000;   // [RULE5]
    if (tx_idx_reg == 8'h01) begin
      tx_word = next_block;   // [RULE6]
    end else if (code_reg == `BTSH_CODE_ERR_TABLE) begin
      if (tx_idx_reg == 8'h02) tx_word = cnt_word_reg;   // [RULE7]
      else if (tx_idx_reg == 8'h03) tx_word = start_word_reg;
      else if (tx_idx_reg >= `BTSH_ERR_FIRST_WORD
               && 16'(tx_idx_reg - `BTSH_ERR_FIRST_WORD) < cnt_word_reg) begin
        tx_word = err_rd_reg;   // [RULE8]
      end
    end else if (tx_idx_reg >= `BTSH_TIME_RD_FIRST && tx_idx_reg <= `BTSH_TIME_RD_LAST) begin
      tx_word = tm_reg[3'(tx_idx_reg - `BTSH_TIME_RD_FIRST)];   // [RULE11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_word_reg  <= 16'h0000;
      rsp_last_reg  <= 1'b0;
    end else begin
      rsp_valid_reg <= (state_reg == BTSH_DEV_SEND);
      rsp_word_reg  <= (state_reg == BTSH_DEV_SEND) ? tx_word : 16'h0000;
      rsp_last_reg  <= (state_reg == BTSH_DEV_SEND) && (tx_idx_reg == len - 8'h01);
    end
  end

  // ---------------------------------------------------------------------
  // Module clock
  // ---------------------------------------------------------------------
  // Order: year, month, day, hour, minute, second, millisecond.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || reinit_reg) begin
      tm_reg[0] <= 16'h07D0;
      tm_reg[1] <= 16'h0001;
      tm_reg[2] <= 16'h0001;
      tm_reg[3] <= 16'h0000;
      tm_reg[4] <= 16'h0000;
      tm_reg[5] <= 16'h0000;
      tm_reg[6] <= 16'h0000;
    end else if (state_reg == BTSH_DEV_DECIDE && code_reg == `BTSH_CODE_TIME_SET) begin
      for (int i = 0; i < 7; i++) begin
        tm_reg[i] <= tset_reg[i];   // [RULE13]
      end
    end else if (time_tick_ms) begin
      tm_reg[6] <= (tm_reg[6] >= 16'h03E7) ? 16'h0000 : tm_reg[6] + 16'h0001;   // [RULE12]
      if (tm_reg[6] >= 16'h03E7) begin
        tm_reg[5] <= (tm_reg[5] >= 16'h003B) ? 16'h0000 : tm_reg[5] + 16'h0001;
        if (tm_reg[5] >= 16'h003B) begin
          tm_reg[4] <= (tm_reg[4] >= 16'h003B) ? 16'h0000 : tm_reg[4] + 16'h0001;
          if (tm_reg[4] >= 16'h003B) begin
            tm_reg[3] <= (tm_reg[3] >= 16'h0017) ? 16'h0000 : tm_reg[3] + 16'h0001;
            if (tm_reg[3] >= 16'h0017) begin
              tm_reg[2] <= (tm_reg[2] >= 16'h001F) ? 16'h0001 : tm_reg[2] + 16'h0001;
              if (tm_reg[2] >= 16'h001F) begin
                tm_reg[1] <= (tm_reg[1] >= 16'h000C) ? 16'h0001 : tm_reg[1] + 16'h0001;
                if (tm_reg[1] >= 16'h000C) tm_reg[0] <= tm_reg[0] + 16'h0001;
              end
            end
          end
        end
      end
    end
  end
endmodule

// [testbench/btsh_assertions.sv]
// Purpose: Link checks for the service handler.
// Assumes: One clock; rst_n synchronous, active low.
// Notes:   Instantiated beside the link interface.
`timescale 1ns/100ps
`include "btsh_regs.svh"
module btsh_assertions (
  input wire logic        ref_clk,   // Clock.
  input wire logic        rst_n,     // Reset, active low.
  input wire logic        req_valid, // Request strobe.
  input wire logic [15:0] req_word,  // Request word.
  input wire logic        req_last,  // Last request word.
  input wire logic        rsp_valid, // Reply strobe.
  input wire logic [15:0] rsp_word,  // Reply word.
  input wire logic        rsp_last   // Last reply word.
);
  logic        in_req_reg;
  logic [15:0] code_reg;
  logic [7:0]  req_cnt_reg;
  logic [7:0]  req_len_reg;
  logic [7:0]  rsp_cnt_reg;
  // ----
  // Helper state: block code and word counts.
  // ----
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_req_reg <= 1'b0;
      code_reg   <= 16'h0000;
    end else if (req_valid) begin
      in_req_reg <= !req_last;
      if (!in_req_reg) code_reg <= req_word;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (req_valid && req_last)) req_cnt_reg <= 8'h00;
    else if (req_valid) req_cnt_reg <= req_cnt_reg + 8'h01;
    if (req_valid && req_last) req_len_reg <= req_cnt_reg + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (rsp_valid && rsp_last)) rsp_cnt_reg <= 8'h00;
    else if (rsp_valid) rsp_cnt_reg <= rsp_cnt_reg + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rsp_gap_free: assert property (rsp_valid && !rsp_last |=> rsp_valid)
    else $error("reply stream has a gap");
  a_req_gap_free: assert property (req_valid && !req_last |=> req_valid)
    else $error("request stream has a gap");
  a_rsp_last_valid: assert property (rsp_last |-> rsp_valid)
    else $error("reply last marker without strobe");
  a_rsp_length: assert property (rsp_last |-> rsp_cnt_reg + 8'h01 == req_len_reg)
    else $error("reply length differs from request length");
  a_reply_delay: assert property ($rose(rsp_valid) |-> $past(req_last, 4))
    else $error("reply not four cycles after request end");
  a_reply_word_zero: assert property ($rose(rsp_valid) |-> rsp_word == 16'h0000)
    else $error("reply word zero is not zero");
  a_err_count_start: assert property ($rose(rsp_valid) && code_reg == `BTSH_CODE_ERR_TABLE
    |-> ##2 rsp_word inside {[16'h0001:16'h00C8]} ##1 rsp_word < 16'h03E8)
    else $error("error reply count or start out of range");
  a_time_fields: assert property (req_valid && req_last && code_reg == `BTSH_CODE_TIME_READ
    |-> ##4 rsp_valid ##3 rsp_word inside {[16'h0001:16'h000C]}
    ##1 rsp_word inside {[16'h0001:16'h001F]} ##1 rsp_word < 16'h0018
    ##1 rsp_word < 16'h003C ##1 rsp_word < 16'h003C ##1 rsp_word < 16'h03E8)
    else $error("time reply missing or field out of range");
  a_no_reply_set: assert property (req_valid && req_last && code_reg inside
    {`BTSH_CODE_TIME_SET, `BTSH_CODE_WARM, `BTSH_CODE_COLD} |=> !rsp_valid [*8])
    else $error("reply sent to a block that takes none");
endmodule

// [testbench/block_transfer_service_handler_tb.sv]
// Purpose: Self-checking bench for both ends of the service handler.
// Assumes: 10 MHz ref_clk; inputs change 1 ns after the rising edge.
// Notes:   Random words come from a 16-bit LFSR seeded with 50156.
`timescale 1ns/100ps
`include "btsh_regs.svh"
module block_transfer_service_handler_tb;
  import btsh_pkg::*;
  logic        ref_clk, rst_n, start, expect_rsp, err_wr_en, time_tick_ms;
  logic        busy, rsp_valid, reinit, time_loaded;
  btsh_size_t  blk_size;
  logic [15:0] blk_word, rsp_word, next_block, err_wr_val, year_out, lfsr;
  logic [7:0]  blk_index, rsp_index;
  logic [10:0] cmd_list_len;
  logic [9:0]  err_wr_idx;
  logic [15:0] req_mem [0:255];
  logic [15:0] rsp_mem [0:255];
  logic [15:0] err_model [0:999];
  logic [15:0] tm [0:6];
  int          n_fail = 0, num_checks = 0, rsp_cnt = 0, n_reinit = 0, n_loaded = 0, cyc = 0;
  int          i, k, r0;
  btsh_link_if link ();
  assign blk_word = req_mem[blk_index];
  btsh_host btsh_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .blk_size(blk_size),
    .start(start), .blk_word(blk_word), .expect_rsp(expect_rsp), .blk_index(blk_index),
    .busy(busy), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_index(rsp_index));
  btsh_device btsh_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .blk_size(blk_size), .cmd_list_len(cmd_list_len), .next_block(next_block),
    .err_wr_en(err_wr_en), .err_wr_idx(err_wr_idx), .err_wr_val(err_wr_val),
    .time_tick_ms(time_tick_ms), .reinit(reinit), .time_loaded(time_loaded), .year_out(year_out));
  btsh_assertions btsh_assertions_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(link.req_valid), .req_word(link.req_word), .req_last(link.req_last),
    .rsp_valid(link.rsp_valid), .rsp_word(link.rsp_word), .rsp_last(link.rsp_last));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----
  // Helpers and checks.
  // ----
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic int len_of(btsh_size_t s);
    return (s == BTSH_SIZE_60) ? 60 : (s == BTSH_SIZE_120) ? 120 : 240;
  endfunction
  function automatic logic [15:0] exp_err(int j, int cnt, int st);
    if (j == 0) return 16'h0000;
    if (j == 1) return next_block;
    if (j == 2) return cnt[15:0];
    if (j == 3) return st[15:0];
    if (j < 4 + cnt) return err_model[st + j - 4];
    return 16'h0000;
  endfunction
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_count(input string name, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic prep(input logic [15:0] code);
    req_mem[0] = code;
    for (int j = 1; j < 256; j++) req_mem[j] = rnd();
  endtask
  task automatic xfer(input logic want, input int n_exp);
    int t;
    rsp_cnt = 0;
    expect_rsp = want;
    start = 1'b1;
    @(posedge ref_clk);
    #1 start = 1'b0;
    t = 0;
    do begin
      @(posedge ref_clk);
      #1 t++;
    end while (busy !== 1'b0 && t < 1000);
    repeat (10) @(posedge ref_clk);
    #1 check_count("reply words", n_exp, rsp_cnt);
    check_word("host idle", 16'h0000, {15'h0000, busy});
  endtask
  task automatic read_time();
    prep(`BTSH_CODE_TIME_READ);
    xfer(1'b1, len_of(blk_size));
    check_word("time word0", 16'h0000, rsp_mem[0]);
    check_word("time word1", next_block, rsp_mem[1]);
    for (int j = 0; j < 7; j++) check_word("time field", tm[j], rsp_mem[j + 2]);
  endtask
  task automatic set_time(input logic edge_case);
    tm[0] = 16'h07D0 + rnd() % 16'h0064;
    tm[1] = 16'h0001 + rnd() % 16'h000C;
    tm[2] = 16'h0001 + rnd() % 16'h001E;
    tm[3] = edge_case ? 16'h0017 : rnd() % 16'h0018;
    tm[4] = edge_case ? 16'h003B : rnd() % 16'h003C;
    tm[5] = edge_case ? 16'h003B : rnd() % 16'h003C;
    tm[6] = edge_case ? 16'h03E7 : rnd() % 16'h03E8;
    prep(`BTSH_CODE_TIME_SET);
    for (int j = 0; j < 7; j++) req_mem[j + 1] = tm[j];
    r0 = n_loaded;
    xfer(1'b0, 0);
    check_count("clock loads", r0 + 1, n_loaded);
    check_word("year", tm[0], year_out);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rsp_valid === 1'b1) begin
      rsp_mem[rsp_index] <= rsp_word;
      rsp_cnt <= rsp_cnt + 1;
    end
    if (reinit === 1'b1) n_reinit <= n_reinit + 1;
    if (time_loaded === 1'b1) n_loaded <= n_loaded + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  // ----
  // Main sequence.
  // ----
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    expect_rsp = 1'b0;
    err_wr_en = 1'b0;
    err_wr_idx = 10'h000;
    err_wr_val = 16'h0000;
    time_tick_ms = 1'b0;
    blk_size = BTSH_SIZE_240;
    cmd_list_len = `BTSH_CMD_MAX;
    lfsr = 16'hC3EC;
    next_block = rnd();
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1 err_wr_en = 1'b1;
    for (i = 0; i < 1000; i++) begin
      err_wr_idx = i[9:0];
      err_wr_val = rnd();
      err_model[i] = err_wr_val;
      @(posedge ref_clk);
      #1;
    end
    err_wr_en = 1'b0;
    for (k = 0; k < 3; k++) begin
      blk_size = btsh_size_t'(k);
      prep(`BTSH_CODE_ERR_TABLE);
      req_mem[1] = (k == 0) ? 16'h0001 : (k == 1) ? 16'h0032 : 16'h00C8;
      req_mem[2] = (k == 0) ? 16'h0000 : (k == 1) ? 16'h03B6 : 16'h0320;
      xfer(1'b1, len_of(blk_size));
      for (i = 0; i < len_of(blk_size); i++)
        check_word("error reply", exp_err(i, req_mem[1], req_mem[2]), rsp_mem[i]);
    end
    $display("Test error table done");
    for (k = 0; k < 5; k++) begin
      prep((k == 4) ? 16'h26DF : `BTSH_CODE_ERR_TABLE);
      req_mem[1] = (k == 0) ? 16'h0000 : (k == 1) ? 16'h00C9 : 16'h000A;
      req_mem[2] = (k == 2) ? 16'h03E8 : (k == 3) ? 16'h03E3 : 16'h0000;
      xfer(1'b0, 0);
    end
    cmd_list_len = 11'h1F4;
    prep(`BTSH_CODE_ERR_TABLE);
    req_mem[1] = 16'h000A;
    req_mem[2] = 16'h01F4;
    xfer(1'b0, 0);
    req_mem[2] = 16'h01EA;
    xfer(1'b1, len_of(blk_size));
    for (i = 0; i < len_of(blk_size); i++)
      check_word("short list", exp_err(i, req_mem[1], req_mem[2]), rsp_mem[i]);
    cmd_list_len = `BTSH_CMD_MAX;
    $display("Test refusals done");
    for (k = 0; k < 3; k++) begin
      blk_size = btsh_size_t'(k);
      set_time(k == 2);
      read_time();
      if (k == 2) begin
        time_tick_ms = 1'b1;
        @(posedge ref_clk);
        #1 time_tick_ms = 1'b0;
        tm[2] = tm[2] + 16'h0001;
        for (i = 3; i < 7; i++) tm[i] = 16'h0000;
        read_time();
      end
      prep((k == 0) ? `BTSH_CODE_WARM : `BTSH_CODE_COLD);
      r0 = n_reinit;
      xfer(1'b0, 0);
      check_count("restart pulses", r0 + 1, n_reinit);
      tm = '{16'h07D0, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      read_time();
    end
    $display("Test time and restart done");
    finish_test();
  end
endmodule
